// *** embedded_ram_map.svh ***
// Constants for the embedded RAM block: capacities, widths and port limits.
`ifndef EMBEDDED_RAM_MAP_SVH
`define EMBEDDED_RAM_MAP_SVH

// -----------------------------------------------------------------------------
// Capacities in bits, parity bits included
// -----------------------------------------------------------------------------
`define RAM_SMALL_BITS   4608
`define RAM_LARGE_BITS   589824
`define RAM_PARITY_NUM   9
`define RAM_PARITY_DEN   8

// -----------------------------------------------------------------------------
// Port carrier limits
// -----------------------------------------------------------------------------
`define RAM_ADDR_W       16
`define RAM_DATA_W       144
`define RAM_SMALL_MAX_W  36

// -----------------------------------------------------------------------------
// Default shapes and neutral ROM pattern
// -----------------------------------------------------------------------------
`define RAM_DEF_WIDTH_A  18
`define RAM_DEF_WIDTH_B  36
`define RAM_DEF_ROM_KEY  144'h0000_0000_0000_0000_0000_0000_0000_0000_5a5a

`endif

// *** embedded_ram_pkg.sv ***
// Types shared by the embedded RAM block and its users.
`include "embedded_ram_map.svh"

package embedded_ram_pkg;

    typedef struct packed {
        logic                    en;
        logic                    we;
        logic [`RAM_ADDR_W-1:0]  addr;
        logic [`RAM_DATA_W-1:0]  wdata;
    } ram_req_t;

    typedef logic [`RAM_DATA_W-1:0] ram_data_t;

endpackage

// *** embedded_ram_block.sv ***
// Embedded dual-port RAM block in a small or a large size with mixed port widths.
//
// Function
// [RULE1] Small block stores 4,608 bits, large 589,824, parity bits included.
// [RULE2] Small shapes: 4Kx1 up to 128x36, parity and plain widths.
// [RULE3] Large shapes: 64Kx8 up to 4Kx144, parity and plain widths.
// [RULE4] A port reading the address it writes returns the new data.
// [RULE5] Cross-port read of a written address: small unknown or old, large unknown.
// [RULE6] Storage and unregistered read outputs come up random and unknown.
// [RULE7] User logic writes every location before it reads it.
// [RULE8] Clear resets output registers only; stored contents stay as they are.
// [RULE9] Preloaded contents only for the small block in read-only mode.
// [RULE10] The two ports may use different widths in both dual-port modes.
// [RULE11] Registered outputs clear at power-up; unregistered ones stay uninitialised.
`timescale 1ns/1ps
`include "embedded_ram_map.svh"

module embedded_ram_block
    import embedded_ram_pkg::*;
#(
    parameter bit                    LARGE     = 1'b0,
    parameter int                    WIDTH_A   = `RAM_DEF_WIDTH_A,
    parameter int                    WIDTH_B   = `RAM_DEF_WIDTH_B,
    parameter bit                    OUT_REG   = 1'b1,
    parameter bit                    OLD_MIXED = 1'b1,
    parameter bit                    ROM_MODE  = 1'b0,
    parameter logic [`RAM_DATA_W-1:0] ROM_KEY  = `RAM_DEF_ROM_KEY
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire ram_req_t   port_a_req,
    input  wire logic       port_a_clr,
    output ram_data_t       port_a_rdata,
    input  wire ram_req_t   port_b_req,
    input  wire logic       port_b_clr,
    output ram_data_t       port_b_rdata
);

    // -------------------------------------------------------------------------
    // Shape
    // -------------------------------------------------------------------------
    localparam int  TOTAL_BITS = LARGE ? `RAM_LARGE_BITS : `RAM_SMALL_BITS;
    localparam bit  PARITY     = (WIDTH_A % `RAM_PARITY_NUM) == 0;
    localparam int  CAP_BITS   = PARITY ? TOTAL_BITS
                                        : TOTAL_BITS / `RAM_PARITY_NUM * `RAM_PARITY_DEN;
    localparam int  UNIT       = (WIDTH_A < WIDTH_B) ? WIDTH_A : WIDTH_B;
    localparam int  NUNITS     = CAP_BITS / UNIT;
    localparam int  RA         = WIDTH_A / UNIT;
    localparam int  RB         = WIDTH_B / UNIT;
    localparam int  DEPTH_A    = CAP_BITS / WIDTH_A;
    localparam int  DEPTH_B    = CAP_BITS / WIDTH_B;
    localparam int  AW_A       = $clog2(DEPTH_A);
    localparam int  AW_B       = $clog2(DEPTH_B);
    localparam int  IW         = $clog2(NUNITS);
    localparam bit  MIX_OLD    = !LARGE && OLD_MIXED;

    function automatic bit width_ok(input int w);
        if (LARGE)
            return w inside {8, 9, 16, 18, 32, 36, 64, 72, 128, 144};
        else
            return w inside {1, 2, 4, 8, 9, 16, 18, 32, 36};
    endfunction

    // Mixed widths must share the parity family and differ by a power of two.
    if (!width_ok(WIDTH_A) || !width_ok(WIDTH_B)) begin : g_bad_width      // [RULE2] [RULE3]
        $error("port width not offered by this block size");
    end
    if ((WIDTH_B % `RAM_PARITY_NUM == 0) != PARITY) begin : g_bad_family   // [RULE10]
        $error("port widths mix parity and plain shapes");
    end
    if (CAP_BITS != DEPTH_A * WIDTH_A || CAP_BITS != DEPTH_B * WIDTH_B) begin : g_bad_cap  // [RULE1]
        $error("shape does not fill the block capacity");
    end
    if (ROM_MODE && LARGE) begin : g_bad_rom                              // [RULE9]
        $error("read-only preloaded mode exists only on the small block");
    end

    // -------------------------------------------------------------------------
    // Address decode and collision detection
    // -------------------------------------------------------------------------
    wire logic [AW_A-1:0]    a_addr    = port_a_req.addr[AW_A-1:0];
    wire logic [AW_B-1:0]    b_addr    = port_b_req.addr[AW_B-1:0];
    wire logic [IW-1:0]      a_base    = IW'(int'(a_addr) * RA);
    wire logic [IW-1:0]      b_base    = IW'(int'(b_addr) * RB);
    wire logic [WIDTH_A-1:0] a_wd      = port_a_req.wdata[WIDTH_A-1:0];
    wire logic [WIDTH_B-1:0] b_wd      = port_b_req.wdata[WIDTH_B-1:0];
    wire logic               a_we      = port_a_req.en && port_a_req.we && !ROM_MODE;
    wire logic               b_we      = port_b_req.en && port_b_req.we && !ROM_MODE;
    wire logic               overlap   = (int'(a_base) < int'(b_base) + RB) &&
                                         (int'(b_base) < int'(a_base) + RA);
    wire logic               a_mix     = b_we && overlap;
    wire logic               b_mix     = a_we && overlap;

    // -------------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------------
    // No reset and no initial value: cells power up random, so the user must
    // write a location before relying on a read of it.                [RULE6] [RULE7]
    logic [UNIT-1:0]    mem [NUNITS];
    logic [WIDTH_A-1:0] a_mem;
    logic [WIDTH_B-1:0] b_mem;

    function automatic logic [UNIT-1:0] rom_word(input int idx);
        return UNIT'(idx) ^ ROM_KEY[UNIT-1:0];
    endfunction

    // Read-only mode takes its contents from the fixed pattern, never from
    // the cells, so it is the only case with known contents at power-up.
    always_comb begin
        a_mem = '0;
        for (int k = 0; k < RA; k++) begin
            a_mem[k*UNIT +: UNIT] = ROM_MODE ? rom_word(int'(a_base) + k)      // [RULE9]
                                             : mem[int'(a_base) + k];
        end
    end

    always_comb begin
        b_mem = '0;
        for (int k = 0; k < RB; k++) begin
            b_mem[k*UNIT +: UNIT] = ROM_MODE ? rom_word(int'(b_base) + k)
                                             : mem[int'(b_base) + k];
        end
    end

    // Both ports may write overlapping cells in one cycle; port B wins then.
    always_ff @(posedge clk) begin
        if (ce) begin
            for (int k = 0; k < RA; k++) begin
                if (a_we) mem[int'(a_base) + k] <= a_wd[k*UNIT +: UNIT];       // [RULE10]
            end
            for (int k = 0; k < RB; k++) begin
                if (b_we) mem[int'(b_base) + k] <= b_wd[k*UNIT +: UNIT];       // [RULE10]
            end
        end
    end

    // -------------------------------------------------------------------------
    // Read data selection
    // -------------------------------------------------------------------------
    wire logic [WIDTH_A-1:0] a_rd_val = a_we  ? a_wd                           // [RULE4]
                                      : a_mix ? (MIX_OLD ? a_mem : 'x)         // [RULE5]
                                      : a_mem;
    wire logic [WIDTH_B-1:0] b_rd_val = b_we  ? b_wd                           // [RULE4]
                                      : b_mix ? (MIX_OLD ? b_mem : 'x)         // [RULE5]
                                      : b_mem;

    // -------------------------------------------------------------------------
    // Read latches and output registers
    // -------------------------------------------------------------------------
    // The read latch has no reset, so unregistered outputs start unknown.
    logic [WIDTH_A-1:0] a_lat_reg;
    logic [WIDTH_B-1:0] b_lat_reg;
    logic [WIDTH_A-1:0] a_out_reg;
    logic [WIDTH_B-1:0] b_out_reg;

    always_ff @(posedge clk) begin
        if (ce && port_a_req.en) a_lat_reg <= a_rd_val;                        // [RULE11]
        if (ce && port_b_req.en) b_lat_reg <= b_rd_val;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_out_reg <= '0;                                                   // [RULE11]
            b_out_reg <= '0;
        end else if (ce) begin
            a_out_reg <= port_a_clr ? '0 : a_lat_reg;                          // [RULE8]
            b_out_reg <= port_b_clr ? '0 : b_lat_reg;                          // [RULE8]
        end
    end

    assign port_a_rdata = ram_data_t'(OUT_REG ? a_out_reg : a_lat_reg);
    assign port_b_rdata = ram_data_t'(OUT_REG ? b_out_reg : b_lat_reg);

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence a_read_s;
        ce && port_a_req.en && !a_we && !a_mix && !ROM_MODE;
    endsequence
    sequence a_pass_s;
        ce && !port_a_clr;
    endsequence

    same_new_a: assert property (ce && a_we |=> a_lat_reg == $past(a_wd)) // [RULE4]
        else $error("port A write did not return new data");
    same_new_b_a: assert property (ce && b_we |=> b_lat_reg == $past(b_wd)) // [RULE4]
        else $error("port B write did not return new data");
    mixed_old_b_a: assert property (                                      // [RULE5]
        MIX_OLD && ce && port_b_req.en && b_mix && !b_we
        |=> b_lat_reg == $past(b_mem))
        else $error("port B cross-port read did not return old data");
    out_clear_a: assert property (ce && port_a_clr |=> a_out_reg == '0)   // [RULE8]
        else $error("clear did not zero port A output register");
    clear_keep_a: assert property (                                       // [RULE8]
        ce && port_a_clr && !a_we && !b_we
        |=> (a_mem == $past(a_mem)) || (a_addr != $past(a_addr)))
        else $error("clear altered stored contents");
    rom_hold_a: assert property (                                         // [RULE9]
        ROM_MODE && ce && port_a_req.we |=> a_addr != $past(a_addr) || a_mem == $past(a_mem))
        else $error("read-only contents changed on a write");
    reset_zero_a: assert property ($rose(rst_n) |-> a_out_reg == '0)     // [RULE11]
        else $error("port A output register not cleared at power-up");
    read_pipe_a: assert property (                                        // [RULE2]
        a_read_s ##1 a_pass_s |=> a_out_reg == $past(a_mem, 2))
        else $error("port A registered read path lost its data");
    width_pad_a: assert property ((port_a_rdata >> WIDTH_A) == '0)        // [RULE10]
        else $error("port A read data above its width not zero");
    mixed_old_a: assert property (                                        // [RULE5]
        MIX_OLD && ce && port_a_req.en && a_mix && !a_we
        |=> a_lat_reg == $past(a_mem))
        else $error("port A cross-port read did not return old data");
    out_clear_b_a: assert property (ce && port_b_clr |=> b_out_reg == '0) // [RULE8]
        else $error("clear did not zero port B output register");
    // A low enable must hold every register, or a stalled user would lose a read.
    ce_freeze_a: assert property (!ce |=> $stable(a_out_reg) && $stable(b_out_reg)
                                          && $stable(a_lat_reg) && $stable(b_lat_reg))
        else $error("register changed while the clock enable was low");

endmodule

// *** ram_user_model.sv ***
// User logic model that drives both RAM ports and their clears.
`timescale 1ns/1ps
module ram_user_model
    import embedded_ram_pkg::*;
(
    input  wire logic clk,
    output ram_req_t  req_a,
    output ram_req_t  req_b,
    output logic      clr_a,
    output logic      clr_b,
    output logic      ce
);
    // Idle ports carry fresh noise, so the RAM cannot lean on stale fields.
    function automatic ram_req_t noisy(ram_req_t r);
        if (!r.en) begin
            r.we    = 1'($urandom);
            r.addr  = 16'($urandom);
            r.wdata = {$urandom, $urandom, $urandom, $urandom, 16'($urandom)};
        end
        return r;
    endfunction

    initial begin
        req_a = '0;
        req_b = '0;
        clr_a = 1'b0;
        clr_b = 1'b0;
        ce    = 1'b1;
    end

    task automatic step(input ram_req_t a, input ram_req_t b, input logic ca, input logic cb,
                        input logic e);
        @(negedge clk);
        req_a = noisy(a);
        req_b = noisy(b);
        clr_a = ca;
        clr_b = cb;
        ce    = e;
    endtask
endmodule

// *** embedded_ram_block_tb.sv ***
// Self-checking bench for the small RAM block, read-write and read-only, 18/36-bit ports.
`timescale 1ns/1ps
`include "embedded_ram_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module embedded_ram_block_tb;
    import embedded_ram_pkg::*;
    logic        clk;
    logic        rst_n   = 1'b0;
    logic        rst_req = 1'b0;
    ram_req_t    req_a, req_b, a, b;
    logic        clr_a, clr_b, ce;
    ram_data_t   rd_a, rd_b;
    int          fails = 0, compares = 0, cycles = 0;
    logic [17:0] mem [256];
    logic [35:0] lat_a, lat_b, out_a, out_b;
    logic [35:0] rom_a, rom_b;
    ram_data_t   rd_ra, rd_rb;
    ram_req_t    idle = '0;
    localparam logic [17:0] KEY = 18'(`RAM_DEF_ROM_KEY);

    ram_user_model i_ram_user_model (.clk(clk), .req_a(req_a), .req_b(req_b), .clr_a(clr_a),
                                     .clr_b(clr_b), .ce(ce));
    embedded_ram_block i_embedded_ram_block (.clk(clk), .rst_n(rst_n), .ce(ce),
        .port_a_req(req_a), .port_a_clr(clr_a), .port_a_rdata(rd_a),
        .port_b_req(req_b), .port_b_clr(clr_b), .port_b_rdata(rd_b));
    embedded_ram_block #(.ROM_MODE(1'b1), .OUT_REG(1'b0)) i_embedded_ram_block_rom (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .port_a_req(req_a), .port_a_clr(clr_a), .port_a_rdata(rd_ra),
        .port_b_req(req_b), .port_b_clr(clr_b), .port_b_rdata(rd_rb));

    function automatic logic [17:0] romu(int i);
        return 18'(i) ^ KEY;
    endfunction

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic ram_req_t rq(logic en, logic we, int addr, ram_data_t d);
        return '{en: en, we: we, addr: 16'(addr), wdata: d};
    endfunction

    function automatic ram_data_t rdat();
        return {$urandom, $urandom, $urandom, $urandom, 16'($urandom)};
    endfunction

    // One cycle: check what the last edge left, then predict the coming edge.
    task automatic cyc(ram_req_t x, ram_req_t y, logic ca, logic cb, logic e);
        logic [35:0] ra, rb;
        i_ram_user_model.step(x, y, ca, cb, e);
        if (!$isunknown(out_a)) `CHK(rd_a, ram_data_t'(out_a))
        if (!$isunknown(out_b)) `CHK(rd_b, ram_data_t'(out_b))
        if (!$isunknown(rom_a)) `CHK(rd_ra, ram_data_t'(rom_a))
        if (!$isunknown(rom_b)) `CHK(rd_rb, ram_data_t'(rom_b))
        rst_n = rst_req;
        if (e && x.en) rom_a = 36'(romu(x.addr[7:0]));
        if (e && y.en) rom_b = {romu({y.addr[6:0], 1'b1}), romu({y.addr[6:0], 1'b0})};
        if (!rst_n) begin
            out_a = '0;
            out_b = '0;
        end else if (e) begin
            ra = x.we ? 36'(x.wdata[17:0]) : 36'(mem[x.addr[7:0]]);
            rb = y.we ? y.wdata[35:0] : {mem[{y.addr[6:0], 1'b1}], mem[{y.addr[6:0], 1'b0}]};
            out_a = ca ? '0 : lat_a;
            out_b = cb ? '0 : lat_b;
            if (x.en) lat_a = ra;
            if (y.en) lat_b = rb;
            if (x.en && x.we) mem[x.addr[7:0]] = x.wdata[17:0];
            if (y.en && y.we) begin
                mem[{y.addr[6:0], 1'b0}] = y.wdata[17:0];
                mem[{y.addr[6:0], 1'b1}] = y.wdata[35:18];
            end
        end
    endtask

    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        void'($urandom(88));
        repeat (16) cyc(idle, idle, 1'b0, 1'b0, 1'b1);
        rst_req = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 256; i++) cyc(rq(1, 1, i, rdat()), idle, 0, 0, 1);
        $display("test fill done");
        cyc(rq(1, 1, 255, rdat()), rq(1, 0, 127, '0), 0, 0, 1);
        cyc(rq(1, 0, 255, '0), rq(1, 1, 127, rdat()), 0, 0, 1);
        cyc(rq(1, 1, 0, rdat()), rq(1, 1, 0, rdat()), 0, 0, 1);
        cyc(rq(1, 1, 3, rdat()), rq(1, 1, 1, rdat()), 1, 1, 0);
        cyc(rq(1, 0, 3, '0), rq(1, 0, 0, '0), 1, 1, 1);
        repeat (3) cyc(idle, idle, 0, 0, 1);
        $display("test corners done");
        repeat (400) begin
            a = rq(1'($urandom), 1'($urandom), $urandom_range(255), rdat());
            b = rq(1'($urandom), 1'($urandom), $urandom_range(127), rdat());
            cyc(a, b, $urandom_range(15) == 0, $urandom_range(15) == 0, $urandom_range(7) != 0);
        end
        $display("test random done");
        rst_req = 1'b0;
        repeat (2) cyc(idle, idle, 0, 0, 1);
        rst_req = 1'b1;
        for (int i = 0; i < 8; i++) cyc(rq(1, 0, i, '0), rq(1, 0, 127 - i, '0), 0, 0, 1);
        repeat (3) cyc(idle, idle, 0, 0, 1);
        $display("test mid reset done");
        final_report();
    end
endmodule
